// >>> spl_host.sv
`timescale 1ns/10ps
// Function
// - Hold mode and reset low 10 ms
// - Wait 20 ms after release before sending
// - Wait 140 cycles after 0x86 echo
// - Wait 90 cycles after 0x79 echo
// - Wait 270 cycles after command echo
// - Wait 1100 cycles before next command
// - Code 0x30 is flash write
// - Code 0x40 is flash read
// - Code 0x90 is flash checksum
// - Code 0xC0 is product identification
// - Code 0xC3 is flash status
// - Code 0xD0 is emulation setting
// - Code 0xFA is security setting
// - Code 0xF0 is flash erase
module spl_host #(
   parameter int GEAR_DIV = 100, // mclk cycles per gear clock cycle
   parameter int BIT_CYCLES = 868, // mclk cycles per UART bit
   parameter int HOLD_CYCLES = spl_pkg::POWERUP_HOLD_LOW_TIME_MS * spl_pkg::MS_CYCLES,
   parameter int SETUP_CYCLES = spl_pkg::RECEIVE_SETUP_WAIT_MS * spl_pkg::MS_CYCLES,
   parameter int ECHO_TIMEOUT = spl_pkg::FLASH_SUM_TIME * 2 // Gear cycles to give up on a reply
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start, // Pulse: run power-up entry and sync
   input wire logic cmd_valid, // User byte request
   input wire logic cmd_first, // Byte is an operation code
   input wire logic [7:0] cmd_byte,
   output logic cmd_ready, // Host can take a user byte
   output logic resp_valid, // Pulse per byte from device
   output logic [7:0] resp_byte,
   output logic linked, // Sync done, commands allowed
   output logic error, // Sync echo mismatch or timeout
   output logic known_op, // Last operation code is a known command
   output logic mode_pin,
   output logic reset_pin,
   output logic txd,
   input wire logic rxd
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   typedef enum {S_IDLE, S_HOLD, S_SETUP, S_SEND, S_ECHO, S_GAP, S_READY} spl_state_t;
   spl_state_t state, next_state;
   logic rxd_meta, rxd_sync; // Pin synchroniser
   logic [31:0] cnt, next_cnt; // Shared wait counter
   logic [6:0] gdiv, next_gdiv; // Gear divider
   logic gear_tick; // One-cycle gear enable
   logic [1:0] phase, next_phase; // 0: 0x86, 1: 0x79, 2: user, 3: operation code waiting out its gap
   logic [7:0] sent, next_sent;
   logic [31:0] gap, next_gap; // Turnaround after the echo
   logic next_cmd_ready, next_resp_valid, next_linked, next_error, next_known_op;
   logic next_mode_pin, next_reset_pin;
   logic [7:0] next_resp_byte;
   logic tx_start, tx_busy, uart_txd, rx_valid;
   logic [7:0] rx_byte, tx_byte;

   // Two flops before anything reads the pin
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end else begin
         rxd_meta <= rxd;
         rxd_sync <= rxd_meta;
      end
   end

   spl_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
      .mclk(mclk), .reset_n(reset_n), .rxd_sync(rxd_sync), .tx_start(tx_start),
      .tx_byte(tx_byte), .tx_busy(tx_busy), .txd(uart_txd), .rx_valid(rx_valid), .rx_byte(rx_byte)
   );

   assign gear_tick = (gdiv == 7'(GEAR_DIV - 1));
   assign tx_start = (state == S_SEND) && !tx_busy;
   assign tx_byte = sent;

   // ****************************************************************
   // Sequencer next-state
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_gdiv = gear_tick ? 7'h00 : gdiv + 7'h01;
      next_phase = phase;
      next_sent = sent;
      next_gap = gap;
      next_cmd_ready = 1'b0;
      next_resp_valid = 1'b0;
      next_resp_byte = resp_byte;
      next_linked = linked;
      next_error = error;
      next_known_op = known_op;
      next_mode_pin = mode_pin;
      next_reset_pin = reset_pin;
      case (state)
         S_IDLE: begin
            if (start) begin
               next_mode_pin = 1'b0;
               next_reset_pin = 1'b0;
               next_linked = 1'b0;
               next_error = 1'b0;
               next_cnt = 32'(HOLD_CYCLES);
               next_state = S_HOLD;
            end
         end
         S_HOLD: begin
            // Both pins low for the power-up hold
            if (cnt != 32'h0) next_cnt = cnt - 32'h1;
            else begin
               next_mode_pin = 1'b1;
               next_reset_pin = 1'b1;
               next_cnt = 32'(SETUP_CYCLES);
               next_state = S_SETUP;
            end
         end
         S_SETUP: begin
            // Nothing on the line until the device is listening
            if (cnt != 32'h0) next_cnt = cnt - 32'h1;
            else begin
               next_phase = 2'h0;
               next_sent = spl_pkg::SYNC_FIRST;
               next_state = S_SEND;
            end
         end
         S_SEND: begin
            if (!tx_busy) begin
               next_cnt = 32'(ECHO_TIMEOUT);
               next_state = S_ECHO;
            end
         end
         S_ECHO: begin
            // Echo arrives after the device's own delay; only the timeout is enforced
            if (rx_valid) begin
               next_resp_valid = 1'b1;
               next_resp_byte = rx_byte;
               // Sync echoes must match; a bad one ends the attempt
               if (phase != 2'h2 && rx_byte != sent) begin
                  next_error = 1'b1;
                  next_state = S_IDLE;
               end else next_state = S_GAP;
               if (phase == 2'h0) next_gap = 32'(spl_pkg::FIRST_SYNC_TURNAROUND);
               else if (phase == 2'h1) next_gap = 32'(spl_pkg::SECOND_SYNC_TURNAROUND);
               else next_gap = 32'(spl_pkg::COMMAND_TURNAROUND);
               next_cnt = next_gap;
            end else if (gear_tick) begin
               // Long enough for the flash checksum reply
               if (cnt == 32'h0) begin
                  next_error = 1'b1;
                  next_state = S_IDLE;
               end else next_cnt = cnt - 32'h1;
            end
         end
         S_GAP: begin
            // Further reply bytes restart the turnaround
            if (rx_valid) begin
               next_resp_valid = 1'b1;
               next_resp_byte = rx_byte;
               next_cnt = gap;
            end else if (gear_tick) begin
               if (cnt != 32'h0) next_cnt = cnt - 32'h1;
               else if (phase == 2'h0) begin
                  next_phase = 2'h1;
                  next_sent = spl_pkg::SYNC_SECOND;
                  next_state = S_SEND;
               end else begin
                  next_phase = 2'h2;
                  next_linked = !error;
                  next_cmd_ready = 1'b1;
                  next_state = S_READY;
               end
            end
         end
         S_READY: begin
            next_cmd_ready = 1'b1;
            if (rx_valid) begin
               // Late reply bytes (read data, sums) still reach the user
               next_resp_valid = 1'b1;
               next_resp_byte = rx_byte;
            end else if (cmd_valid) begin
               next_cmd_ready = 1'b0;
               next_sent = cmd_byte;
               if (cmd_first) begin
                  // Decode of the operation codes the loader knows
                  case (cmd_byte)
                     spl_pkg::OP_FLASH_WRITE,
                     spl_pkg::OP_FLASH_READ,
                     spl_pkg::OP_FLASH_SUM,
                     spl_pkg::OP_PRODUCT_ID,
                     spl_pkg::OP_FLASH_STATUS,
                     spl_pkg::OP_EMULATION,
                     spl_pkg::OP_SECURITY,
                     spl_pkg::OP_FLASH_ERASE: next_known_op = 1'b1;
                     default: next_known_op = 1'b0;
                  endcase
                  // Command gap before a new operation code
                  next_cnt = 32'(spl_pkg::NEXT_COMMAND_GAP);
                  next_state = S_GAP;
                  next_phase = 2'h3;
               end else next_state = S_SEND;
            end
         end
         default: next_state = S_IDLE;
      endcase
      // Phase 3 marks a pending operation code after its gap
      if (state == S_GAP && phase == 2'h3 && gear_tick && cnt == 32'h0 && !rx_valid) begin
         next_phase = 2'h2;
         next_cmd_ready = 1'b0;
         next_state = S_SEND;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         cnt <= 32'h0;
         gdiv <= 7'h00;
         phase <= 2'h0;
         sent <= 8'h00;
         gap <= 32'h0;
         cmd_ready <= 1'b0;
         resp_valid <= 1'b0;
         resp_byte <= 8'h00;
         linked <= 1'b0;
         error <= 1'b0;
         known_op <= 1'b0;
         mode_pin <= 1'b0;
         reset_pin <= 1'b0;
         txd <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         gdiv <= next_gdiv;
         phase <= next_phase;
         sent <= next_sent;
         gap <= next_gap;
         cmd_ready <= next_cmd_ready;
         resp_valid <= next_resp_valid;
         resp_byte <= next_resp_byte;
         linked <= next_linked;
         error <= next_error;
         known_op <= next_known_op;
         mode_pin <= next_mode_pin;
         reset_pin <= next_reset_pin;
         txd <= uart_txd;
      end
   end
endmodule : spl_host

// >>> spl_pkg.sv
package spl_pkg;
   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_MHZ = 100;                        // mclk rate in MHz
   localparam int POWERUP_HOLD_LOW_TIME_MS = 10;        // Mode and reset held low after power-up
   localparam int RECEIVE_SETUP_WAIT_MS = 20;           // Wait after release before first byte
   localparam int MS_CYCLES = CLK_MHZ * 1000;           // mclk cycles per millisecond
   // Device-side figures in gear clock cycles
   localparam int FIRST_SYNC_ECHO_DELAY = 660;
   localparam int SECOND_SYNC_ECHO_DELAY = 540;
   localparam int COMMAND_ECHO_DELAY = 300;
   localparam int FLASH_SUM_TIME = 2800000;
   localparam int RAM_SUM_TIME = 160;
   localparam int WRITE_RESPONSE_DELAY = 200;
   localparam int READ_RESPONSE_DELAY = 430;
   localparam int EMULATION_ECHO_DELAY = 420;
   localparam int PROTECT_ENABLE_TIME = 1080;
   // Host-side gaps in gear clock cycles
   localparam int FIRST_SYNC_TURNAROUND = 140;
   localparam int SECOND_SYNC_TURNAROUND = 90;
   localparam int COMMAND_TURNAROUND = 270;
   localparam int NEXT_COMMAND_GAP = 1100;
   // ****************************************************************
   // Bytes and operation codes
   // ****************************************************************
   localparam logic [7:0] SYNC_FIRST = 8'h86;
   localparam logic [7:0] SYNC_SECOND = 8'h79;
   localparam logic [7:0] OP_FLASH_WRITE = 8'h30;
   localparam logic [7:0] OP_FLASH_READ = 8'h40;
   localparam logic [7:0] OP_FLASH_SUM = 8'h90;
   localparam logic [7:0] OP_PRODUCT_ID = 8'hC0;
   localparam logic [7:0] OP_FLASH_STATUS = 8'hC3;
   localparam logic [7:0] OP_EMULATION = 8'hD0;
   localparam logic [7:0] OP_SECURITY = 8'hFA;
   localparam logic [7:0] OP_FLASH_ERASE = 8'hF0;
   localparam int UART_BITS = 10;                       // Start, 8 data, stop
endpackage : spl_pkg

// >>> spl_uart.sv
`timescale 1ns/10ps
// ****************************************************************
// Byte-wide UART transmitter and receiver, 8N1, LSB first
// ****************************************************************
module spl_uart #(
   parameter int BIT_CYCLES = 868 // mclk cycles per bit
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rxd_sync, // Already synchronised receive line
   input wire logic tx_start, // One-cycle pulse, taken only when idle
   input wire logic [7:0] tx_byte,
   output logic tx_busy,
   output logic txd,
   output logic rx_valid, // One-cycle pulse per received byte
   output logic [7:0] rx_byte
);
   localparam int CW = $clog2(BIT_CYCLES + 1);
   // Transmit state
   logic [CW-1:0] tx_cnt, next_tx_cnt;
   logic [3:0] tx_bit, next_tx_bit;
   logic [9:0] tx_shift, next_tx_shift;
   logic next_tx_busy, next_txd;
   // Receive state
   logic [CW-1:0] rx_cnt, next_rx_cnt;
   logic [3:0] rx_bit, next_rx_bit;
   logic [7:0] next_rx_byte;
   logic rx_busy, next_rx_busy, next_rx_valid;

   // Next-state for both directions
   always_comb begin
      next_tx_cnt = tx_cnt;
      next_tx_bit = tx_bit;
      next_tx_shift = tx_shift;
      next_tx_busy = tx_busy;
      next_txd = txd;
      next_rx_cnt = rx_cnt;
      next_rx_bit = rx_bit;
      next_rx_byte = rx_byte;
      next_rx_busy = rx_busy;
      next_rx_valid = 1'b0;
      if (!tx_busy) begin
         // Idle line stays high
         if (tx_start) begin
            next_tx_shift = {1'b1, tx_byte, 1'b0};
            next_tx_busy = 1'b1;
            next_tx_bit = 4'h0;
            next_tx_cnt = CW'(BIT_CYCLES - 1);
            next_txd = 1'b0;
         end
      end else if (tx_cnt != '0) begin
         next_tx_cnt = tx_cnt - 1'b1;
      end else if (tx_bit == 4'(spl_pkg::UART_BITS - 1)) begin
         next_tx_busy = 1'b0;
         next_txd = 1'b1;
      end else begin
         // Shift out the next bit
         next_tx_bit = tx_bit + 1'b1;
         next_tx_cnt = CW'(BIT_CYCLES - 1);
         next_txd = tx_shift[tx_bit + 1'b1];
      end
      if (!rx_busy) begin
         // Start bit: sample centres from half a bit on
         if (!rxd_sync) begin
            next_rx_busy = 1'b1;
            next_rx_bit = 4'h0;
            next_rx_cnt = CW'(BIT_CYCLES / 2);
         end
      end else if (rx_cnt != '0) begin
         next_rx_cnt = rx_cnt - 1'b1;
      end else begin
         next_rx_cnt = CW'(BIT_CYCLES - 1);
         next_rx_bit = rx_bit + 1'b1;
         if (rx_bit == 4'h0 && rxd_sync) begin
            next_rx_busy = 1'b0;                        // Glitch, not a start bit
         end else if (rx_bit == 4'(spl_pkg::UART_BITS - 1)) begin
            next_rx_busy = 1'b0;
            next_rx_valid = rxd_sync;                   // Framing error drops the byte
         end else if (rx_bit != 4'h0) begin
            next_rx_byte = {rxd_sync, rx_byte[7:1]};
         end
      end
   end

   // Registers only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_cnt <= '0;
         tx_bit <= 4'h0;
         tx_shift <= 10'h3FF;
         tx_busy <= 1'b0;
         txd <= 1'b1;
         rx_cnt <= '0;
         rx_bit <= 4'h0;
         rx_byte <= 8'h00;
         rx_busy <= 1'b0;
         rx_valid <= 1'b0;
      end else begin
         tx_cnt <= next_tx_cnt;
         tx_bit <= next_tx_bit;
         tx_shift <= next_tx_shift;
         tx_busy <= next_tx_busy;
         txd <= next_txd;
         rx_cnt <= next_rx_cnt;
         rx_bit <= next_rx_bit;
         rx_byte <= next_rx_byte;
         rx_busy <= next_rx_busy;
         rx_valid <= next_rx_valid;
      end
   end
endmodule : spl_uart

// >>> spl_host_props.sv
`timescale 1ns/10ps
// ********************
// Pin and turnaround checks at the host ports
// ********************
module spl_host_props #(
   parameter int GEAR_DIV = 100,
   parameter int HOLD_CYCLES = 1000000,
   parameter int SETUP_CYCLES = 2000000
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_first,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_ready,
   input wire logic resp_valid,
   input wire logic [7:0] resp_byte,
   input wire logic linked,
   input wire logic error,
   input wire logic known_op,
   input wire logic mode_pin,
   input wire logic reset_pin,
   input wire logic txd
);
   // Two cycles of slack: resp_valid lags the device stop bit
   localparam int GAP1 = spl_pkg::FIRST_SYNC_TURNAROUND * GEAR_DIV - 2;
   localparam int GAP2 = spl_pkg::SECOND_SYNC_TURNAROUND * GEAR_DIV - 2;
   localparam int GAP3 = spl_pkg::COMMAND_TURNAROUND * GEAR_DIV - 2;
   localparam int GAPN = spl_pkg::NEXT_COMMAND_GAP * GEAR_DIV - 2;
   localparam int LINK_AT = GAP2 + 12; // Latest point for linked
   localparam int CAP = GAPN + 16; // Saturation keeps counters small
   int low_cnt; // Cycles with the device held in reset
   int rel_cnt; // Cycles since the pins were released
   int gap_cnt; // Cycles since the last device byte
   logic [7:0] last_rx;
   logic [7:0] last_op;
   logic op_pend; // Operation code taken, start bit not yet sent

   function automatic logic known(input logic [7:0] b);
      return b inside {spl_pkg::OP_FLASH_WRITE, spl_pkg::OP_FLASH_READ, spl_pkg::OP_FLASH_SUM,
         spl_pkg::OP_PRODUCT_ID, spl_pkg::OP_FLASH_STATUS, spl_pkg::OP_EMULATION,
         spl_pkg::OP_SECURITY, spl_pkg::OP_FLASH_ERASE};
   endfunction : known

   // Helper counters; last_rx is wiped while the device is held in reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt <= 0;
         rel_cnt <= 0;
         gap_cnt <= 0;
         last_rx <= 8'h00;
         last_op <= 8'h00;
         op_pend <= 1'h0;
      end else begin
         low_cnt <= mode_pin ? 0 : (low_cnt < HOLD_CYCLES ? low_cnt + 1 : low_cnt);
         rel_cnt <= !mode_pin ? 0 : (rel_cnt < SETUP_CYCLES ? rel_cnt + 1 : rel_cnt);
         gap_cnt <= resp_valid ? 0 : (gap_cnt < CAP ? gap_cnt + 1 : gap_cnt);
         last_rx <= !mode_pin ? 8'h00 : (resp_valid ? resp_byte : last_rx);
         last_op <= (cmd_valid && cmd_ready && cmd_first) ? cmd_byte : last_op;
         op_pend <= (cmd_valid && cmd_ready) ? cmd_first : (op_pend && txd);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence release_s;
      $rose(mode_pin);
   endsequence
   sequence start_bit_s;
      $fell(txd);
   endsequence

   hold_low_a: assert property (release_s |-> low_cnt >= HOLD_CYCLES - 1)
      else $error("device pins released too early");
   pin_order_a: assert property ($rose(reset_pin) |-> mode_pin)
      else $error("reset pin released before mode pin");
   setup_wait_a: assert property (start_bit_s |-> rel_cnt >= SETUP_CYCLES - 1)
      else $error("byte sent too soon after release");
   quiet_reset_a: assert property (!reset_pin |-> txd)
      else $error("line active while device held");
   first_turn_a: assert property (start_bit_s ##0 (last_rx == spl_pkg::SYNC_FIRST) |-> gap_cnt >= GAP1)
      else $error("short gap after first echo");
   second_turn_a: assert property (start_bit_s ##0 (last_rx == spl_pkg::SYNC_SECOND) |-> gap_cnt >= GAP2)
      else $error("short gap after second echo");
   cmd_turn_a: assert property (start_bit_s ##0 linked |-> gap_cnt >= GAP3)
      else $error("short gap after command reply");
   next_cmd_a: assert property (start_bit_s ##0 op_pend |-> gap_cnt >= GAPN)
      else $error("operation code sent too early");
   link_rise_a: assert property ($rose(linked) |-> last_rx == spl_pkg::SYNC_SECOND)
      else $error("linked without second echo");
   link_late_a: assert property ((last_rx == spl_pkg::SYNC_SECOND && gap_cnt >= LINK_AT && !error) |-> linked)
      else $error("linked missing after second echo");
   ready_link_a: assert property (cmd_ready |-> linked && !error)
      else $error("ready outside linked phase");
   resp_pulse_a: assert property (resp_valid |=> !resp_valid)
      else $error("response strobe too long");
   known_code_a: assert property ((cmd_valid && cmd_ready && cmd_first) |=> ##[0:2] known_op == known(last_op))
      else $error("known operation flag wrong");
endmodule : spl_host_props

bind spl_host spl_host_props #(.GEAR_DIV(GEAR_DIV), .HOLD_CYCLES(HOLD_CYCLES), .SETUP_CYCLES(SETUP_CYCLES)) props_u (
   .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_byte(cmd_byte),
   .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_byte(resp_byte), .linked(linked), .error(error),
   .known_op(known_op), .mode_pin(mode_pin), .reset_pin(reset_pin), .txd(txd));

// >>> spl_dev_model.sv
`timescale 1ns/10ps
// ********************
// Behavioural device in serial loader mode
// ********************
module spl_dev_model #(
   parameter int GEAR_DIV = 2,
   parameter int BIT_CYCLES = 8,
   parameter int FLASH_SUM = 800, // Shortened flash sum time, gear cycles
   parameter int INFO_GAP = 100, // Reply delay where none is fixed
   parameter logic [7:0] ID_BYTE = 8'h3C, // Arbitrary identification value
   parameter logic [7:0] ACK = 8'h5A, // Completion byte
   parameter logic [7:0] SUM_BYTE = 8'hA7  // Reported flash sum
) (
   input wire logic mclk,
   input wire logic mode_pin,
   input wire logic reset_pin,
   input wire logic txd,
   input wire logic [1:0] fault, // Bit 0 corrupts first echo, bit 1 mutes
   output logic rxd
);
   logic secured = 1'h0;  // Protection is kept in flash, so resets leave it

   // Receive one 8N1 byte, sampled mid-bit
   task automatic get(output logic [7:0] b);
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge mclk);
         b[i] = txd;
      end
      repeat (BIT_CYCLES) @(posedge mclk);
   endtask : get

   // Send one 8N1 byte, LSB first
   task automatic send(input logic [7:0] b);
      rxd <= 1'h0;
      repeat (BIT_CYCLES) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         rxd <= b[i];
         repeat (BIT_CYCLES) @(posedge mclk);
      end
      rxd <= 1'h1;
      repeat (BIT_CYCLES) @(posedge mclk);
   endtask : send

   // Wait g gear cycles, then answer unless muted
   task automatic reply(input int g, input logic [7:0] b);
      repeat (g * GEAR_DIV) @(posedge mclk);
      if (!fault[1]) send(b);
   endtask : reply

   task automatic serve();
      logic [7:0] b;
      logic [7:0] op;
      get(b);
      reply(spl_pkg::FIRST_SYNC_ECHO_DELAY, fault[0] ? b ^ 8'h01 : b);
      get(b);
      reply(spl_pkg::SECOND_SYNC_ECHO_DELAY, b);
      forever begin
         get(op);
         reply(spl_pkg::COMMAND_ECHO_DELAY, op);
         case (op)
            8'h30: begin get(b); reply(spl_pkg::WRITE_RESPONSE_DELAY, ACK); end
            8'h40: begin
               get(b);
               for (int i = 0; i < b; i++) reply(i == 0 ? spl_pkg::READ_RESPONSE_DELAY : 0, 8'hA0 + 8'(i));
            end
            8'h90: reply(FLASH_SUM, SUM_BYTE);
            8'hC0: reply(INFO_GAP, ID_BYTE);
            8'hC3: reply(INFO_GAP, {7'h00, secured});
            8'hD0: begin get(b); reply(spl_pkg::EMULATION_ECHO_DELAY, b); end
            8'hFA: begin get(b); reply(spl_pkg::PROTECT_ENABLE_TIME, ACK); secured = 1'h1; end
            8'hF0: begin secured = 1'h0; reply(INFO_GAP, ACK); end
            default: ;  // Unknown codes get only their echo
         endcase
      end
   endtask : serve

   // Line idles high by pull-up; a reset pin fall aborts any exchange
   always begin : life
      rxd = 1'h1;
      wait (mode_pin === 1'h1 && reset_pin === 1'h1);
      fork
         serve();
         @(negedge reset_pin);
      join_any
      disable fork;
   end
endmodule : spl_dev_model

// >>> spl_host_tb_top.sv
`timescale 1ns/10ps
// ********************
// Self-checking bench for the loader host
// ********************
module spl_host_tb_top;
   localparam int GD = 2; // Short gear divider keeps the run brief
   localparam logic [7:0] ID_BYTE = 8'h3C; // Arbitrary identification value
   localparam logic [7:0] ACK = 8'h5A;
   localparam logic [7:0] SUM_BYTE = 8'hA7;
   logic mclk = 1'h0;
   logic reset_n, start, cmd_valid, cmd_first, cmd_ready, resp_valid, linked, error, known_op;
   logic mode_pin, reset_pin, txd, rxd;
   logic [7:0] cmd_byte, resp_byte;
   logic [1:0] fault;
   logic [7:0] rq[$];  // Device bytes seen at the host
   int n_errors = 0;
   int compares = 0;

   always #5 mclk = ~mclk;

   spl_host #(.GEAR_DIV(GD), .BIT_CYCLES(8), .HOLD_CYCLES(50), .SETUP_CYCLES(50), .ECHO_TIMEOUT(2000)) dut_u (
      .mclk(mclk), .reset_n(reset_n), .start(start), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
      .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_byte(resp_byte),
      .linked(linked), .error(error), .known_op(known_op), .mode_pin(mode_pin), .reset_pin(reset_pin),
      .txd(txd), .rxd(rxd));
   spl_dev_model #(.GEAR_DIV(GD), .BIT_CYCLES(8), .ID_BYTE(ID_BYTE), .ACK(ACK), .SUM_BYTE(SUM_BYTE)) dev_u (
      .mclk(mclk), .mode_pin(mode_pin), .reset_pin(reset_pin), .txd(txd), .fault(fault), .rxd(rxd));

   // Collected mid-cycle, where the one-cycle strobe is settled
   always @(negedge mclk) begin
      if (resp_valid === 1'h1) rq.push_back(resp_byte);
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // Offer a byte and hold it until an edge that sees ready high
   task automatic put(input logic [7:0] b, input logic f);
      int k;
      k = 0;
      @(posedge mclk);
      cmd_valid <= 1'h1;
      cmd_byte <= b;
      cmd_first <= f;
      @(negedge mclk);
      while (cmd_ready !== 1'h1 && k < 20000) begin @(negedge mclk); k++; end
      @(posedge mclk);
      cmd_valid <= 1'h0;
   endtask : put

   // One command: code, optional data byte, then all replies and ready again
   task automatic xfer(input logic [7:0] op, input int nd, input logic [7:0] d, input int nr);
      int k;
      k = 0;
      rq.delete();
      put(op, 1'h1);
      if (nd > 0) put(d, 1'h0);
      while ((rq.size() < nr || cmd_ready !== 1'h1) && k < 20000) begin @(negedge mclk); k++; end
      chk(8'(rq.size()), 8'(nr));
      chk(rq[0], op);
   endtask : xfer

   task automatic t_entry(input logic [1:0] f, input logic ok);
      int k;
      k = 0;
      rq.delete();
      @(posedge mclk);
      fault <= f;
      start <= 1'h1;
      @(posedge mclk);
      start <= 1'h0;
      repeat (3) @(negedge mclk);
      while (linked !== 1'h1 && error !== 1'h1 && k < 20000) begin @(negedge mclk); k++; end
      chk({7'h00, error}, {7'h00, !ok});
      chk({7'h00, linked}, {7'h00, ok});
      if (ok) chk(rq[0], spl_pkg::SYNC_FIRST);
      if (ok) chk(rq[1], spl_pkg::SYNC_SECOND);
      $display("entry with fault %0d done", f);
   endtask : t_entry

   task automatic t_codes();
      xfer(spl_pkg::OP_FLASH_WRITE, 1, 8'h3A, 2);
      chk(rq[1], ACK);
      xfer(spl_pkg::OP_FLASH_READ, 1, 8'h03, 4);
      for (int i = 1; i < 4; i++) chk(rq[i], 8'h9F + 8'(i));
      xfer(spl_pkg::OP_FLASH_SUM, 0, 8'h00, 2);
      chk(rq[1], SUM_BYTE);
      xfer(spl_pkg::OP_PRODUCT_ID, 0, 8'h00, 2);
      chk(rq[1], ID_BYTE);
      chk({7'h00, known_op}, 8'h01);
      xfer(spl_pkg::OP_EMULATION, 1, 8'h5C, 2);
      chk(rq[1], 8'h5C);
      $display("operation codes done");
   endtask : t_codes

   // Protection set, reported, then cleared by erase
   task automatic t_protect();
      xfer(spl_pkg::OP_SECURITY, 1, 8'h01, 2);
      chk(rq[1], ACK);
      xfer(spl_pkg::OP_FLASH_STATUS, 0, 8'h00, 2);
      chk(rq[1], 8'h01);
      xfer(spl_pkg::OP_FLASH_ERASE, 0, 8'h00, 2);
      chk(rq[1], ACK);
      xfer(spl_pkg::OP_FLASH_STATUS, 0, 8'h00, 2);
      chk(rq[1], 8'h00);
      $display("protection done");
   endtask : t_protect

   task automatic t_unknown();
      xfer(8'h11, 0, 8'h00, 1);
      chk({7'h00, known_op}, 8'h00);
      $display("unknown code done");
   endtask : t_unknown

   // Main sequence: bad echo, mute device, then a clean session
   initial begin
      reset_n = 1'h0;
      start = 1'h0;
      cmd_valid = 1'h0;
      cmd_first = 1'h0;
      cmd_byte = 8'h00;
      fault = 2'h0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'h1;
      t_entry(2'h1, 1'h0);
      t_entry(2'h2, 1'h0);
      t_entry(2'h0, 1'h1);
      t_codes();
      t_protect();
      t_unknown();
      close_out();
   end

   // Watchdog sized well past the expected run
   initial begin
      repeat (95000) @(posedge mclk);
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
   end
endmodule : spl_host_tb_top
